// ==== phy_control_pkg.sv ====
// constants for the phy control register block
package phy_control_pkg;
  localparam logic [4:0]  PHY_CONTROL_ADDR   = 5'h00;
  localparam logic [15:0] PHY_CONTROL_RESET  = 16'h3100;
  localparam int          BIT_REG_RESET      = 15;
  localparam int          BIT_LOOPBACK       = 14;
  localparam int          BIT_SPEED_SELECT   = 13;
  localparam int          BIT_AUTONEG_ENABLE = 12;
  localparam int          BIT_POWER_DOWN     = 11;
  localparam int          BIT_ISOLATE        = 10;
  localparam int          BIT_AUTONEG_RESTART = 9;
  localparam int          BIT_DUPLEX         = 8;
  localparam int          BIT_COLLISION_TEST = 7;
  localparam logic [15:0] RESERVED_MASK      = 16'h007f;
  localparam logic [3:0]  SOFT_RESET_CYCLES  = 4'h4;
endpackage

// ==== soft_reset_timer.sv ====
// stretches a soft reset request into a fixed internal reset pulse
`timescale 1ns/1ps
`default_nettype none
module soft_reset_timer #(
  parameter logic [3:0] CYCLES = phy_control_pkg::SOFT_RESET_CYCLES
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // request and pulse
  input  wire logic start,
  output logic      busy
);
  logic [3:0] count_ff;
  wire  [3:0] nxt_count = start ? CYCLES : (count_ff != 4'h0 ? count_ff - 4'h1 : 4'h0);
  assign busy = (count_ff != 4'h0);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) count_ff <= 4'h0;
    else if (ce) count_ff <= nxt_count;
  end
endmodule
`default_nettype wire

// ==== phy_control_register.sv ====
// phy control register at management address zero
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE1 - register reads 0x3100 after any reset
// RULE2 - bit 13 selects 100 Mb/s when set, 10 Mb/s when clear
// RULE3 - bit 8 set gives full duplex, reset value one
// RULE4 - bit 8 clear gives half duplex
// RULE5 - management writes and autoneg result both update the duplex bit
// RULE6 - bit 7 set enables collision test mode, reset zero
// RULE7 - collision test bit sets on transmit start, clears on transmit halt
// RULE8 - master writes zeros to bits 6:0 and ignores their read value
// RULE9 - writing bit 15 resets registers and state, then hardware clears it
// RULE10 - access only through serial management write and read transactions
module phy_control_register
  import phy_control_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // management transaction port
  input  wire logic [4:0]  mgmt_addr,
  input  wire logic        mgmt_wr,
  input  wire logic        mgmt_rd,
  input  wire logic [15:0] mgmt_tx_data_holding,
  output logic      [15:0] mgmt_rx_data_holding,
  output logic             mgmt_rd_valid,
  // phy internal events
  input  wire logic        autoneg_done,
  input  wire logic        autoneg_full_duplex,
  input  wire logic        tx_start,
  input  wire logic        tx_halt,
  input  wire logic        autoneg_restart_done,
  // control outputs
  output logic             speed_select,
  output logic             full_duplex,
  output logic             collision_test,
  output logic             autoneg_enable,
  output logic             autoneg_restart,
  output logic             power_down,
  output logic             isolate,
  output logic             loopback_mode,
  output logic             state_reset
);
  import phy_control_pkg::*;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  logic [15:0] phy_control_ff;
  logic        rd_valid_ff;
  logic [15:0] rd_data_ff;
  logic        sreset_busy;
  wire         hit      = (mgmt_addr == PHY_CONTROL_ADDR);
  wire         wr_hit   = mgmt_wr && hit; // RULE10
  wire         rd_hit   = mgmt_rd && hit; // RULE10
  wire         sreset_req = wr_hit && mgmt_tx_data_holding[BIT_REG_RESET]; // RULE9

  // ------------------------------------------------------------
  // next register value
  // ------------------------------------------------------------
  logic [15:0] nxt_phy_control;
  always_comb begin
    nxt_phy_control = phy_control_ff;
    if (sreset_req) begin
      // defaults restored; bit 15 held high while internal reset runs
      nxt_phy_control = PHY_CONTROL_RESET; // RULE9
      nxt_phy_control[BIT_REG_RESET] = 1'b1;
    end else if (wr_hit) begin
      // reserved field stored as zero whatever the master sent
      nxt_phy_control = mgmt_tx_data_holding & ~RESERVED_MASK; // RULE8
    end else begin
      if (autoneg_done) nxt_phy_control[BIT_DUPLEX] = autoneg_full_duplex; // RULE5
      if (autoneg_restart_done) nxt_phy_control[BIT_AUTONEG_RESTART] = 1'b0;
      if (!sreset_busy) nxt_phy_control[BIT_REG_RESET] = 1'b0; // RULE9
    end
    // set wins over clear when both arrive together
    if (tx_halt) nxt_phy_control[BIT_COLLISION_TEST] = 1'b0; // RULE7
    if (tx_start) nxt_phy_control[BIT_COLLISION_TEST] = 1'b1; // RULE7
  end

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) phy_control_ff <= PHY_CONTROL_RESET; // RULE1
    else if (ce) phy_control_ff <= nxt_phy_control;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_valid_ff <= 1'b0;
      rd_data_ff  <= 16'h0000;
    end else if (ce) begin
      rd_valid_ff <= rd_hit;
      if (rd_hit) rd_data_ff <= phy_control_ff; // RULE10
    end
  end

  // ------------------------------------------------------------
  // soft reset stretcher
  // ------------------------------------------------------------
  soft_reset_timer #(.CYCLES(SOFT_RESET_CYCLES)) u_sreset (
    .clk   (clk),
    .rst   (rst),
    .ce    (ce),
    .start (sreset_req),
    .busy  (sreset_busy)
  );

  // ------------------------------------------------------------
  // outputs straight from flip-flops
  // ------------------------------------------------------------
  assign mgmt_rx_data_holding = rd_data_ff;
  assign mgmt_rd_valid        = rd_valid_ff;
  assign speed_select    = phy_control_ff[BIT_SPEED_SELECT];   // RULE2
  assign full_duplex     = phy_control_ff[BIT_DUPLEX];         // RULE3 RULE4
  assign collision_test  = phy_control_ff[BIT_COLLISION_TEST]; // RULE6
  assign autoneg_enable  = phy_control_ff[BIT_AUTONEG_ENABLE];
  assign autoneg_restart = phy_control_ff[BIT_AUTONEG_RESTART];
  assign power_down      = phy_control_ff[BIT_POWER_DOWN];
  assign isolate         = phy_control_ff[BIT_ISOLATE];
  assign loopback_mode   = phy_control_ff[BIT_LOOPBACK];
  assign state_reset     = phy_control_ff[BIT_REG_RESET];      // RULE9

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  reset_value_a: assert property (@(posedge clk) $fell(rst) |-> phy_control_ff == PHY_CONTROL_RESET) // RULE1
    else $error("control register not at default after reset");
  speed_follow_a: assert property (@(posedge clk) disable iff (rst)
    ce && wr_hit && !sreset_req |=> speed_select == $past(mgmt_tx_data_holding[13])) // RULE2
    else $error("speed select not written");
  duplex_full_a: assert property (@(posedge clk) disable iff (rst)
    ce && wr_hit && !sreset_req && mgmt_tx_data_holding[8] && !tx_start |=> full_duplex) // RULE3
    else $error("full duplex not set by write");
  duplex_half_a: assert property (@(posedge clk) disable iff (rst)
    ce && wr_hit && !sreset_req && !mgmt_tx_data_holding[8] |=> !full_duplex) // RULE4
    else $error("half duplex not set by write");
  duplex_autoneg_a: assert property (@(posedge clk) disable iff (rst)
    ce && !wr_hit && autoneg_done |=> full_duplex == $past(autoneg_full_duplex)) // RULE5
    else $error("autoneg duplex not stored");
  coll_set_a: assert property (@(posedge clk) disable iff (rst)
    ce && tx_start |=> collision_test) // RULE6
    else $error("collision test not set on transmit start");
  coll_clear_a: assert property (@(posedge clk) disable iff (rst)
    ce && tx_halt && !tx_start |=> !collision_test) // RULE7
    else $error("collision test not cleared on halt");
  reserved_zero_a: assert property (@(posedge clk) disable iff (rst)
    (phy_control_ff & RESERVED_MASK) == 16'h0000)
    else $error("reserved field not zero");
  sreset_clear_a: assert property (@(posedge clk) disable iff (rst)
    ce && sreset_req ##1 ce [*6] |-> !state_reset) // RULE9
    else $error("soft reset bit not cleared");
  read_back_a: assert property (@(posedge clk) disable iff (rst)
    ce && rd_hit |=> mgmt_rd_valid && mgmt_rx_data_holding == $past(phy_control_ff)) // RULE10
    else $error("read data wrong");

  // ------------------------------------------------------------
  // checks: field writes and restart bit clear
  // ------------------------------------------------------------
  coll_write_a: assert property (@(posedge clk) disable iff (rst)
    ce && wr_hit && !sreset_req && !tx_start && !tx_halt
    |=> collision_test == $past(mgmt_tx_data_holding[BIT_COLLISION_TEST])) // RULE6
    else $error("collision test not written");
  fields_write_a: assert property (@(posedge clk) disable iff (rst)
    ce && wr_hit && !sreset_req
    |=> {loopback_mode, autoneg_enable, power_down, isolate, autoneg_restart}
        == $past({mgmt_tx_data_holding[14], mgmt_tx_data_holding[12:9]}))
    else $error("control fields not written");
  write_priority_a: assert property (@(posedge clk) disable iff (rst)
    ce && wr_hit && !sreset_req && autoneg_done
    |=> full_duplex == $past(mgmt_tx_data_holding[BIT_DUPLEX])) // RULE5
    else $error("write lost to autoneg result");
  restart_clear_a: assert property (@(posedge clk) disable iff (rst)
    ce && autoneg_restart_done && !wr_hit |=> !autoneg_restart)
    else $error("restart bit not cleared");

  // ------------------------------------------------------------
  // checks: soft reset
  // ------------------------------------------------------------
  sreset_default_a: assert property (@(posedge clk) disable iff (rst)
    ce && sreset_req && !tx_start |=> phy_control_ff == (PHY_CONTROL_RESET | 16'h8000)) // RULE9
    else $error("soft reset did not restore defaults");
  sreset_hold_a: assert property (@(posedge clk) disable iff (rst)
    ce && sreset_req ##1 (ce && !wr_hit) [*4] |-> state_reset) // RULE9
    else $error("soft reset bit dropped early");
  sreset_idle_a: assert property (@(posedge clk) disable iff (rst)
    ce && !wr_hit && !sreset_busy |=> !state_reset) // RULE9
    else $error("soft reset bit stuck");

  // ------------------------------------------------------------
  // checks: bus, reset and clock enable
  // ------------------------------------------------------------
  // other addresses must leave the register untouched
  other_addr_a: assert property (@(posedge clk) disable iff (rst)
    ce && mgmt_wr && !hit && !tx_start && !tx_halt && !autoneg_done
    && !autoneg_restart_done && !state_reset |=> $stable(phy_control_ff)) // RULE10
    else $error("write to other address changed register");
  stray_read_a: assert property (@(posedge clk) disable iff (rst)
    ce && mgmt_rd && !hit |=> !mgmt_rd_valid) // RULE10
    else $error("read of other address answered");
  rdvalid_pulse_a: assert property (@(posedge clk) disable iff (rst)
    ce && !rd_hit |=> !mgmt_rd_valid) // RULE10
    else $error("read valid without read");
  rx_hold_a: assert property (@(posedge clk) disable iff (rst)
    ce && !rd_hit |=> $stable(mgmt_rx_data_holding)) // RULE10
    else $error("read data changed without read");
  reset_hold_a: assert property (@(posedge clk)
    rst |-> phy_control_ff == PHY_CONTROL_RESET && !mgmt_rd_valid
    && mgmt_rx_data_holding == 16'h0000) // RULE1
    else $error("state not at default during reset");
  // a low enable must freeze every stored bit
  freeze_hold_a: assert property (@(posedge clk) disable iff (rst)
    !ce |=> $stable(phy_control_ff) && $stable(mgmt_rd_valid)
    && $stable(mgmt_rx_data_holding))
    else $error("state changed while clock enable low");
endmodule
`default_nettype wire

// ==== mgmt_master.sv ====
// management master model for the control register
`timescale 1ns/1ps
`default_nettype none
module mgmt_master (
  // clock
  input  wire logic        clk,
  // management transaction port
  output var  logic [4:0]  addr,
  output var  logic        wr,
  output var  logic        rd,
  output var  logic [15:0] txd
);
  initial begin
    addr = 5'h00;
    wr   = 1'b0;
    rd   = 1'b0;
    txd  = 16'h0000;
  end
  task automatic write(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk);
    addr = a;
    txd  = d & ~16'h007f;
    wr   = 1'b1;
    @(negedge clk);
    wr   = 1'b0;
    // released lines must not keep their last value
    addr = ~a;
    txd  = ~txd;
  endtask
  task automatic read(input logic [4:0] a);
    @(negedge clk);
    addr = a;
    rd   = 1'b1;
    @(negedge clk);
    rd   = 1'b0;
    addr = ~a;
  endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the phy control register
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import phy_control_pkg::*;
  logic        clk, rst, ce, an_done, an_fd, tx_start, tx_halt, an_rs_done, wr, rd, rd_valid;
  logic        ss, fd, ct, ae, ar, pd, iso, lb, sr;
  logic [4:0]  addr;
  logic [15:0] txd, rxd, d;
  logic [15:0] exp_q[$];
  integer      seed = 25;
  int          fails = 0;
  int          total_checks = 0;
  mgmt_master m (.clk(clk), .addr(addr), .wr(wr), .rd(rd), .txd(txd));
  phy_control_register DUT (.clk(clk), .rst(rst), .ce(ce), .mgmt_addr(addr),
    .mgmt_wr(wr), .mgmt_rd(rd), .mgmt_tx_data_holding(txd), .mgmt_rx_data_holding(rxd),
    .mgmt_rd_valid(rd_valid), .autoneg_done(an_done), .autoneg_full_duplex(an_fd),
    .tx_start(tx_start), .tx_halt(tx_halt), .autoneg_restart_done(an_rs_done),
    .speed_select(ss), .full_duplex(fd), .collision_test(ct), .autoneg_enable(ae),
    .autoneg_restart(ar), .power_down(pd), .isolate(iso), .loopback_mode(lb),
    .state_reset(sr));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd_exp(input logic [15:0] e);
    exp_q.push_back(e);
    m.read(PHY_CONTROL_ADDR);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  task automatic conclude;
    $display("checks=%0d mismatches=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // an answer with nothing pending means a stray response
  always @(negedge clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(16'h0000, 16'hffff);
      else chk(rxd, exp_q.pop_front());
    end
  end
  initial begin
    {rst, an_done, an_fd, tx_start, tx_halt, an_rs_done} = 6'b100000;
    ce = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    rd_exp(PHY_CONTROL_RESET);
    chk({12'h000, ss, fd, ae, ct}, 16'h000e);
    for (int i = 0; i < 6; i++) begin
      d = 16'($random(seed)) & 16'h7e80;
      d[8] = i[0];
      m.write(PHY_CONTROL_ADDR, d);
      chk({7'h00, sr, lb, ss, ae, pd, iso, ar, fd, ct}, {7'h00, d[15:7]});
      rd_exp(d);
    end
    m.write(5'h01, 16'h0000);
    m.read(5'h1f);
    rd_exp(d);
    pulse(an_done);
    d[8] = 1'b0;
    rd_exp(d);
    d = 16'h1200;
    m.write(PHY_CONTROL_ADDR, d);
    chk({15'h0000, ar}, 16'h0001);
    pulse(an_rs_done);
    d[9] = 1'b0;
    rd_exp(d);
    pulse(tx_start);
    d[7] = 1'b1;
    chk({15'h0000, ct}, 16'h0001);
    rd_exp(d);
    pulse(tx_halt);
    d[7] = 1'b0;
    rd_exp(d);
    // frozen block must ignore a transmit start
    @(negedge clk);
    ce = 1'b0;
    pulse(tx_start);
    ce = 1'b1;
    chk({15'h0000, ct}, 16'h0000);
    rd_exp(d);
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rd_exp(PHY_CONTROL_RESET);
    m.write(PHY_CONTROL_ADDR, 16'h8000);
    chk({15'h0000, sr}, 16'h0001);
    repeat (8) @(negedge clk);
    rd_exp(PHY_CONTROL_RESET);
    repeat (3) @(negedge clk);
    chk(16'(exp_q.size()), 16'h0000);
    conclude;
  end
  initial begin
    #50000;
    fails++;
    conclude;
  end
endmodule
`default_nettype wire
